// *** flr_top.sv ***
// fault thresholds and over-temperature response of a point-of-load regulator
// assumes a management engine delivering decoded commands and measurements on clock_i
// What this block does
// RL1: each phase current is compared alone against the over-current limit; phase a trips it, phase b only with two phases.
// RL2: with two phases both are checked against the per-phase limit, so either phase above it trips, whatever the total.
// RL3: each phase current is compared alone against the under-current limit; phase a trips it, phase b only with two phases.
// RL4: a 16-bit over-temperature fault limit is held and exceeding it is an over-temperature fault.
// RL5: in every response mode a fault pulls the alert line low and sets its status flag.
// RL6: response code 10 shuts the output at once and then restarts per retry count and delay.
// RL7: response code 11 shuts the output at once and restarts only when temperature falls below warning.
// RL8: a retry count of zero means no restart until the fault is cleared.
// RL9: retry counts 001 to 110 limit the restart attempts to that number.
// RL10: retry count 111 retries without limit until commanded off or another fault shuts down.
// RL11: the retry interval is the delay field plus one times 35 ms.
// RL12: a 16-bit warning limit is held and also serves as the resume level.
// RL13: a 16-bit input over-voltage limit is held and exceeding it is an input over-voltage fault.
// RL14: the action setting moves as single bytes and the limits as two-byte words.
// RL15: the alert stays low until the host clears the flag, and response codes 00 and 01 are reserved.
`timescale 1ns/100ps
`include "flr_consts.svh"
module flr_top
  import flr_pkg::*;
#(
  parameter int unsigned RETRY_UNIT_CYCLES = `FLR_RETRY_UNIT_MS * `FLR_CYC_PER_MS
)
(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // command port
  input  wire logic             cmd_valid_i,
  input  wire logic             cmd_write_i,
  input  wire logic             cmd_word_i,
  input  wire logic [7:0]       cmd_code_i,
  input  wire logic [15:0]      cmd_wdata_i,
  output logic                  cmd_done_o,
  output logic                  cmd_error_o,
  output logic [15:0]           cmd_rdata_o,
  // measurements
  input  wire flr_pkg::flr_lin_t phase_a_current_i,
  input  wire flr_pkg::flr_lin_t phase_b_current_i,
  input  wire flr_pkg::flr_lin_t temperature_i,
  input  wire flr_pkg::flr_lin_t input_voltage_i,
  input  wire logic             two_phase_i,
  // power stage control
  input  wire logic             operation_on_i,
  input  wire logic             other_fault_i,
  output logic                  output_enable_o,
  // open-drain alert pin
  input  wire logic             fault_alert_line_i,
  output logic                  fault_alert_line_o,
  output logic                  fault_alert_line_oe_n_o
);
  import flr_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [15:0] oc_limit, next_oc_limit;
  logic [15:0] uc_limit, next_uc_limit;
  logic [15:0] ot_fault, next_ot_fault;
  logic [15:0] ot_warn,  next_ot_warn;
  logic [15:0] vin_ov,   next_vin_ov;
  logic [7:0]  ot_action, next_ot_action;
  logic [4:0]  status, next_status;
  logic        done, next_done;
  logic        error, next_error;
  logic [15:0] rdata, next_rdata;
  logic        line_meta, line_sync;
  flr_state_t  state, next_state;
  logic [2:0]  attempts, next_attempts;
  logic [31:0] timer, next_timer;
  logic        out_en, next_out_en;

  // -----------------------------------------------------------------
  // comparators
  // -----------------------------------------------------------------
  flr_cmp_if cmp_bus[`FLR_NUM_CMP] ();
  logic [`FLR_NUM_CMP-1:0] hit;

  assign cmp_bus[`FLR_CMP_OC_A].lhs = phase_a_current_i;
  assign cmp_bus[`FLR_CMP_OC_A].rhs = oc_limit;
  assign cmp_bus[`FLR_CMP_OC_B].lhs = phase_b_current_i;
  assign cmp_bus[`FLR_CMP_OC_B].rhs = oc_limit;
  assign cmp_bus[`FLR_CMP_UC_A].lhs = uc_limit;
  assign cmp_bus[`FLR_CMP_UC_A].rhs = phase_a_current_i;
  assign cmp_bus[`FLR_CMP_UC_B].lhs = uc_limit;
  assign cmp_bus[`FLR_CMP_UC_B].rhs = phase_b_current_i;
  assign cmp_bus[`FLR_CMP_OT].lhs   = temperature_i;
  assign cmp_bus[`FLR_CMP_OT].rhs   = ot_fault;
  assign cmp_bus[`FLR_CMP_OTW].lhs  = temperature_i;
  assign cmp_bus[`FLR_CMP_OTW].rhs  = ot_warn;
  assign cmp_bus[`FLR_CMP_COOL].lhs = ot_warn;
  assign cmp_bus[`FLR_CMP_COOL].rhs = temperature_i;
  assign cmp_bus[`FLR_CMP_VIN].lhs  = input_voltage_i;
  assign cmp_bus[`FLR_CMP_VIN].rhs  = vin_ov;

  for (genvar g = 0; g < `FLR_NUM_CMP; g++)
  begin : g_cmp
    flr_lin_cmp u_cmp (.port(cmp_bus[g]));
    assign hit[g] = cmp_bus[g].lhs_gt;
  end

  // -----------------------------------------------------------------
  // fault events
  // -----------------------------------------------------------------
  // phase b only counts when it is really wired in, so a floating
  // measurement in single-phase builds cannot raise the over- or under-current flag or the alert
  logic oc_evt, uc_evt, ot_evt, otw_evt, vin_evt, cool;
  logic [1:0] resp;
  logic [2:0] retry_cfg, delay_cfg;
  assign oc_evt    = hit[`FLR_CMP_OC_A] | (two_phase_i & hit[`FLR_CMP_OC_B]); // RL1 RL2
  assign uc_evt    = hit[`FLR_CMP_UC_A] | (two_phase_i & hit[`FLR_CMP_UC_B]); // RL3 RL2
  assign ot_evt    = hit[`FLR_CMP_OT];      // RL4
  assign otw_evt   = hit[`FLR_CMP_OTW];     // RL12
  assign cool      = hit[`FLR_CMP_COOL];    // RL12
  assign vin_evt   = hit[`FLR_CMP_VIN];     // RL13
  assign resp      = ot_action[`FLR_RESP_HI:`FLR_RESP_LO];
  assign retry_cfg = ot_action[`FLR_RETRY_HI:`FLR_RETRY_LO];
  assign delay_cfg = ot_action[`FLR_DELAY_HI:`FLR_DELAY_LO];

  // -----------------------------------------------------------------
  // command decode, limit registers and sticky status
  // -----------------------------------------------------------------
  always_comb
  begin
    logic is_word;
    logic known;
    is_word        = 1'b1;
    known          = 1'b1;
    next_oc_limit  = oc_limit;
    next_uc_limit  = uc_limit;
    next_ot_fault  = ot_fault;
    next_ot_warn   = ot_warn;
    next_vin_ov    = vin_ov;
    next_ot_action = ot_action;
    next_done      = cmd_valid_i;
    next_error     = 1'b0;
    next_rdata     = rdata;
    next_status    = status;
    unique case (cmd_code_i)
      `FLR_CMD_OC_LIMIT:  next_rdata = oc_limit;
      `FLR_CMD_UC_LIMIT:  next_rdata = uc_limit;
      `FLR_CMD_OT_FAULT:  next_rdata = ot_fault;
      `FLR_CMD_OT_WARN:   next_rdata = ot_warn;
      `FLR_CMD_VIN_OV:    next_rdata = vin_ov;
      `FLR_CMD_OT_ACTION:
      begin
        is_word    = 1'b0;
        next_rdata = {8'h00, ot_action};
      end
      `FLR_CMD_STATUS:
      begin
        is_word    = 1'b0;
        next_rdata = {8'h00, line_sync, 2'h0, status};
      end
      default:
      begin
        known      = 1'b0;
        next_rdata = 16'h0000;
      end
    endcase
    // a transfer of the wrong size is refused whole
    if (cmd_valid_i && (!known || (cmd_word_i != is_word))) // RL14
    begin
      next_error = 1'b1;
      next_rdata = 16'h0000;
    end
    else if (cmd_valid_i && cmd_write_i)
    begin
      next_rdata = 16'h0000;
      unique case (cmd_code_i)
        `FLR_CMD_OC_LIMIT:  next_oc_limit  = cmd_wdata_i;
        `FLR_CMD_UC_LIMIT:  next_uc_limit  = cmd_wdata_i;
        `FLR_CMD_OT_FAULT:  next_ot_fault  = cmd_wdata_i;
        `FLR_CMD_OT_WARN:   next_ot_warn   = cmd_wdata_i;
        `FLR_CMD_VIN_OV:    next_vin_ov    = cmd_wdata_i;
        `FLR_CMD_OT_ACTION: next_ot_action = cmd_wdata_i[7:0];
        `FLR_CMD_STATUS:    next_status    = status & ~cmd_wdata_i[4:0]; // RL15
        default:            next_rdata     = 16'h0000;
      endcase
    end
    else if (!cmd_valid_i)
    begin
      next_rdata = 16'h0000;
    end
    // set wins over a clear in the same cycle; every response mode flags it
    next_status[`FLR_ST_OC]  = next_status[`FLR_ST_OC]  | oc_evt;  // RL5
    next_status[`FLR_ST_UC]  = next_status[`FLR_ST_UC]  | uc_evt;  // RL5
    next_status[`FLR_ST_OT]  = next_status[`FLR_ST_OT]  | ot_evt;  // RL5
    next_status[`FLR_ST_OTW] = next_status[`FLR_ST_OTW] | otw_evt; // RL5
    next_status[`FLR_ST_VIN] = next_status[`FLR_ST_VIN] | vin_evt; // RL5
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      oc_limit                <= `FLR_RST_HI_LIMIT;
      uc_limit                <= `FLR_RST_LO_LIMIT;
      ot_fault                <= `FLR_RST_HI_LIMIT;
      ot_warn                 <= `FLR_RST_HI_LIMIT;
      vin_ov                  <= `FLR_RST_HI_LIMIT;
      ot_action               <= `FLR_RST_ACTION;
      status                  <= 5'h00;
      done                    <= 1'b0;
      error                   <= 1'b0;
      rdata                   <= 16'h0000;
      line_meta               <= 1'b1;
      line_sync               <= 1'b1;
      fault_alert_line_oe_n_o <= 1'b1;
      fault_alert_line_o      <= 1'b0;
    end
    else
    begin
      oc_limit                <= next_oc_limit;
      uc_limit                <= next_uc_limit;
      ot_fault                <= next_ot_fault;
      ot_warn                 <= next_ot_warn;
      vin_ov                  <= next_vin_ov;
      ot_action               <= next_ot_action;
      status                  <= next_status;
      done                    <= next_done;
      error                   <= next_error;
      rdata                   <= next_rdata;
      line_meta               <= fault_alert_line_i;
      line_sync               <= line_meta;
      // drive low while any flag stands; released only by the host clear
      fault_alert_line_oe_n_o <= ~(|next_status); // RL5 RL15
      fault_alert_line_o      <= 1'b0;
    end
  end

  assign cmd_done_o  = done;
  assign cmd_error_o = error;
  assign cmd_rdata_o = rdata;

  // -----------------------------------------------------------------
  // over-temperature shutdown sequencer
  // -----------------------------------------------------------------
  // codes 00 and 01 flag and alert only; the output is left running
  always_comb
  begin
    logic [2:0] budget;
    // a fresh episode draws on the programmed count directly, so a fault that
    // lands right after the action write still gets its full retry budget
    budget        = status[`FLR_ST_OT] ? attempts : retry_cfg; // RL9
    next_state    = state;
    next_attempts = attempts;
    next_timer    = timer;
    // the budget refills only once the host has acknowledged the fault
    if (!status[`FLR_ST_OT] && !ot_evt && state == st_run)
    begin
      next_attempts = retry_cfg;
    end
    unique case (state)
      st_run:
      begin
        if (other_fault_i)
        begin
          next_state = st_hold;
        end
        else if (ot_evt && resp == `FLR_RESP_RETRY) // RL6
        begin
          if (retry_cfg == `FLR_RETRY_NONE || (budget == 3'h0 && retry_cfg != `FLR_RETRY_FOREVER)) // RL8 RL9
          begin
            next_state = st_hold;
          end
          else
          begin
            next_state    = st_delay;
            next_attempts = budget; // RL9
            next_timer = 32'(({29'h0, delay_cfg} + 32'h1) * RETRY_UNIT_CYCLES - 32'h1); // RL11
          end
        end
        else if (ot_evt && resp == `FLR_RESP_RESUME) // RL7
        begin
          next_state = st_resume;
        end
      end
      st_delay:
      begin
        if (other_fault_i)
        begin
          next_state = st_hold; // RL10
        end
        else if (!operation_on_i)
        begin
          next_state = st_run; // RL10
        end
        else if (timer == 32'h0)
        begin
          next_state = st_run;
          if (retry_cfg != `FLR_RETRY_FOREVER) // RL10
          begin
            next_attempts = attempts - 3'h1; // RL9
          end
        end
        else
        begin
          next_timer = timer - 32'h1;
        end
      end
      st_resume:
      begin
        if (other_fault_i)
        begin
          next_state = st_hold;
        end
        else if (cool)
        begin
          next_state = st_run; // RL7
        end
      end
      st_hold:
      begin
        if (!other_fault_i && !status[`FLR_ST_OT] && !ot_evt)
        begin
          next_state = st_run; // RL8
        end
      end
    endcase
    next_out_en = (next_state == st_run) && operation_on_i && !other_fault_i; // RL6 RL7
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state    <= st_run;
      attempts <= 3'h0;
      timer    <= 32'h0;
      out_en   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      attempts <= next_attempts;
      timer    <= next_timer;
      out_en   <= next_out_en;
    end
  end

  assign output_enable_o = out_en;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_oc_phase_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL1
    hit[`FLR_CMP_OC_A] |=> status[`FLR_ST_OC]) else $error("phase a over-current not flagged");
  a_two_phase_b: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL2
    (two_phase_i && hit[`FLR_CMP_OC_B]) |=> status[`FLR_ST_OC]) else $error("phase b over-current not flagged");
  a_uc_phase_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL3
    hit[`FLR_CMP_UC_A] |=> status[`FLR_ST_UC]) else $error("under-current not flagged");
  a_ot_fault_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL4
    ot_evt |=> status[`FLR_ST_OT] && !fault_alert_line_oe_n_o) else $error("over-temperature not flagged");
  a_alert_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL15
    (!fault_alert_line_oe_n_o && !(cmd_valid_i && cmd_write_i)) |=> !fault_alert_line_oe_n_o)
    else $error("alert released without host clear");
  a_alert_any_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL5
    vin_evt |=> !fault_alert_line_oe_n_o && status[`FLR_ST_VIN]) else $error("alert not driven on fault");
  a_retry_shutoff: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL6
    (state == st_run && ot_evt && resp == `FLR_RESP_RETRY) |=> !output_enable_o)
    else $error("output not disabled on retry fault");
  a_resume_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL7
    (state == st_resume && !cool && !other_fault_i) |=> state == st_resume && !output_enable_o)
    else $error("resumed before cooling");
  a_no_retry_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL8
    (state == st_hold && status[`FLR_ST_OT]) |=> state == st_hold) else $error("left hold while fault stands");
  a_retry_count: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL9
    (state == st_delay && timer == 32'h0 && operation_on_i && !other_fault_i && retry_cfg != `FLR_RETRY_FOREVER)
    |=> attempts == $past(attempts) - 3'h1) else $error("retry budget not spent");
  a_retry_forever: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL10
    (state == st_delay && timer == 32'h0 && retry_cfg == `FLR_RETRY_FOREVER) |=> attempts == $past(attempts))
    else $error("unlimited retry spent budget");
  a_delay_load: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL11
    (state == st_run && next_state == st_delay)
    |=> timer == 32'(({29'h0, $past(delay_cfg)} + 32'h1) * RETRY_UNIT_CYCLES - 32'h1))
    else $error("retry delay loaded wrong");
endmodule

// *** flr_consts.svh ***
// command codes, field positions, reset values and timing figures of the fault limit block
// assumes inclusion by bare name from the package and the design modules
`ifndef FLR_CONSTS_SVH
`define FLR_CONSTS_SVH

// -----------------------------------------------------------------
// command codes
// -----------------------------------------------------------------
`define FLR_CMD_OC_LIMIT   8'h46
`define FLR_CMD_UC_LIMIT   8'h4B
`define FLR_CMD_OT_FAULT   8'h4F
`define FLR_CMD_OT_ACTION  8'h50
`define FLR_CMD_OT_WARN    8'h51
`define FLR_CMD_VIN_OV     8'h55
`define FLR_CMD_STATUS     8'hE0

// -----------------------------------------------------------------
// fields of the over-temperature action byte
// -----------------------------------------------------------------
`define FLR_RESP_HI        7
`define FLR_RESP_LO        6
`define FLR_RETRY_HI       5
`define FLR_RETRY_LO       3
`define FLR_DELAY_HI       2
`define FLR_DELAY_LO       0
`define FLR_RESP_RETRY     2'h2
`define FLR_RESP_RESUME    2'h3
`define FLR_RETRY_NONE     3'h0
`define FLR_RETRY_FOREVER  3'h7

// -----------------------------------------------------------------
// status byte bits and comparator slots
// -----------------------------------------------------------------
`define FLR_ST_OC          0
`define FLR_ST_UC          1
`define FLR_ST_OT          2
`define FLR_ST_OTW         3
`define FLR_ST_VIN         4
`define FLR_ST_LINE        7
`define FLR_NUM_CMP        8
`define FLR_CMP_OC_A       0
`define FLR_CMP_OC_B       1
`define FLR_CMP_UC_A       2
`define FLR_CMP_UC_B       3
`define FLR_CMP_OT         4
`define FLR_CMP_OTW        5
`define FLR_CMP_COOL       6
`define FLR_CMP_VIN        7

// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define FLR_RST_HI_LIMIT   16'h7BFF
`define FLR_RST_LO_LIMIT   16'h7C00
`define FLR_RST_ACTION     8'h80
`define FLR_RETRY_UNIT_MS  35
`define FLR_CYC_PER_MS     100000

`endif

// *** flr_pkg.sv ***
// types shared by the fault limit block
// assumes flr_consts.svh is on the include path
package flr_pkg;
  `include "flr_consts.svh"

  // over-temperature shutdown sequencer
  typedef enum logic [1:0] {
    st_run    = 2'b00,
    st_hold   = 2'b01,
    st_delay  = 2'b10,
    st_resume = 2'b11
  } flr_state_t;

  typedef logic [15:0] flr_lin_t;
endpackage

// *** flr_cmp_if.sv ***
// carrier between the top and its linear-format comparators
// assumes both ends run combinationally on the same clock domain
`timescale 1ns/100ps
interface flr_cmp_if;
  logic [15:0] lhs;
  logic [15:0] rhs;
  logic        lhs_gt;
  modport cmp  (input lhs, input rhs, output lhs_gt);
  modport user (output lhs, output rhs, input lhs_gt);
endinterface

// *** flr_lin_cmp.sv ***
// magnitude comparator for two 16-bit linear-format values
// assumes 5-bit signed exponent above an 11-bit signed mantissa
`timescale 1ns/100ps
module flr_lin_cmp
(
  // operands and result
  flr_cmp_if.cmp port
);
  // -----------------------------------------------------------------
  // scale both operands onto one fixed-point grid
  // -----------------------------------------------------------------
  // exponent range -16..15 is offset to a 0..31 left shift, so no bits are lost
  function automatic logic signed [47:0] lin_val(input logic [15:0] v);
    logic signed [47:0] mant;
    logic        [4:0]  shift;
    mant  = {{37{v[10]}}, v[10:0]};
    shift = {~v[15], v[14:11]};
    return mant <<< shift;
  endfunction

  // result is pure logic; the caller registers it
  assign port.lhs_gt = lin_val(port.lhs) > lin_val(port.rhs);
endmodule

// *** flr_host_model.sv ***
// management host stand-in that issues one command transfer at a time
// assumes each call starts just after a rising clock edge
`timescale 1ns/100ps
module flr_host_model
(
  // clock
  input  wire logic        clock_i,
  // command port toward the block
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic             cmd_word_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o
);
  // idle lines at time zero
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_word_o  = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 16'h0000;
  end

  // one strobe per transfer; bad flips the transfer size to provoke a refusal
  task automatic xfer(input logic wr, input logic [7:0] cd, input logic [15:0] wd, input logic bad);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_word_o  = (cd != 8'h50 && cd != 8'hE0) ^ bad;
    cmd_code_o  = cd;
    cmd_wdata_o = wd;
    @(posedge clock_i);
    #1;
    // lines left behind carry junk so a stale value can never pass as valid
    cmd_valid_o = 1'b0;
    cmd_write_o = ~wr;
    cmd_code_o  = ~cd;
    cmd_wdata_o = ~wd;
  endtask
endmodule

// *** fault_limit_and_ot_response_tb.sv ***
// self-checking bench for the fault limits and over-temperature response
// assumes flr_pkg, flr_cmp_if, flr_lin_cmp, flr_top and flr_host_model are compiled first
`timescale 1ns/100ps
module fault_limit_and_ot_response_tb;
  import flr_pkg::*;
  // retry unit shortened so a retry delay lasts tens of cycles, not millions
  localparam int U = 10;
  localparam flr_lin_t NI = 16'h0040, NV = 16'h0030, COOL = 16'h0019, HOT = 16'h0078, WARM = 16'h005A;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_valid, cmd_write, cmd_word, done, err;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rdata, r;
  flr_lin_t    ia = NI, ib = NI, temp = COOL, vin = NV;
  logic        two_ph = 1'b0, op_on = 1'b1, oth = 1'b0;
  logic        en, ad_o, ad_oe_n, pin;
  logic [16:0] expq[$];
  int          mismatches = 0, cmp_count = 0;
  logic [7:0]  cd[6] = '{8'h46, 8'h4B, 8'h4F, 8'h50, 8'h51, 8'h55};
  logic [15:0] rv[6] = '{16'h7BFF, 16'h7C00, 16'h7BFF, 16'h0080, 16'h7BFF, 16'h7BFF};
  logic [15:0] pv[6] = '{16'h0064, 16'h0032, 16'h0064, 16'h0080, 16'h0050, 16'h0050};

  // open-drain alert pin with its pull-up
  assign pin = ad_oe_n ? 1'b1 : ad_o;
  always #5 clock_i = ~clock_i;

  flr_top #(.RETRY_UNIT_CYCLES(U)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_word_i(cmd_word), .cmd_code_i(cmd_code),
    .cmd_wdata_i(cmd_wdata), .cmd_done_o(done), .cmd_error_o(err), .cmd_rdata_o(rdata),
    .phase_a_current_i(ia), .phase_b_current_i(ib), .temperature_i(temp), .input_voltage_i(vin),
    .two_phase_i(two_ph), .operation_on_i(op_on), .other_fault_i(oth), .output_enable_o(en),
    .fault_alert_line_i(pin), .fault_alert_line_o(ad_o), .fault_alert_line_oe_n_o(ad_oe_n));

  flr_host_model host (.clock_i(clock_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_word_o(cmd_word), .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] ex);
    cmp_count++;
    if (seen !== ex)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // every input change lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // note the expected answer, then let the host issue the transfer
  task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] wd, input logic bad,
                     input logic [16:0] ex);
    expq.push_back(ex);
    host.xfer(wr, c, wd, bad);
    tick(1);
  endtask

  // raise one measurement fault, read status, restore, clear and read again
  task automatic probe(input flr_lin_t a, input flr_lin_t b, input logic tp, input flr_lin_t v,
                       input logic [7:0] st);
    ia = a;
    ib = b;
    two_ph = tp;
    vin = v;
    tick(4);
    cmd(0, 8'hE0, 0, 0, {9'h000, st});
    ia = NI;
    ib = NI;
    vin = NV;
    cmd(1, 8'hE0, 16'h001F, 0, 0);
    tick(4);
    cmd(0, 8'hE0, 0, 0, 17'h00080);
  endtask

  // over-temperature episode: trip, off time, restart count, recovery once cool and cleared
  task automatic ot(input logic [7:0] act, input int lo, input int ri);
    int   n;
    int   tot;
    logic pr;
    cmd(1, 8'h50, {8'h00, act}, 0, 0);
    temp = HOT;
    n = 0;
    while (en !== 1'b0 && n < 5)
    begin
      tick(1);
      n++;
    end
    chk("trip delay", 17'(n <= 2), 17'h00001);
    n = 0;
    while (en === 1'b0 && n < 300)
    begin
      tick(1);
      n++;
    end
    chk("off time", 17'(n), 17'(lo));
    tot = (n < 300);
    pr = en;
    repeat (300)
    begin
      tick(1);
      tot += (en === 1'b1 && pr !== 1'b1);
      pr = en;
    end
    chk("restarts", tot > 20 ? 17'd99 : 17'(tot), 17'(ri));
    temp = COOL;
    cmd(1, 8'hE0, 16'h001F, 0, 0);
    tick(15);
    chk("recovered", 17'(en), 17'h00001);
  endtask

  // answers are matched in order against the oldest note
  always @(negedge clock_i)
    if (done === 1'b1)
    begin
      if (expq.size() == 0)
        chk("stray answer", 17'h00000, 17'h1FFFF);
      else
        chk("answer", {err, rdata}, expq.pop_front());
    end

  // watchdog well beyond the few thousand cycles the run needs
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end

  // -----------------------------------------------------------------
  // stimulus
  // -----------------------------------------------------------------
  initial
  begin
    void'($urandom(82168));
    repeat (6) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    tick(4);
    cmd(0, 8'hE0, 0, 0, 17'h00080);
    for (int i = 0; i < 6; i++)
      cmd(0, cd[i], 0, 0, {1'b0, rv[i]});
    for (int i = 0; i < 6; i++)
    begin
      r = $urandom();
      if (i == 3)
        r[15:8] = 8'h00;
      cmd(1, cd[i], r, 0, 0);
      cmd(0, cd[i], 0, 0, {1'b0, r});
    end
    for (int i = 0; i < 6; i++)
      cmd(1, cd[i], pv[i], 0, 0);
    cmd(1, 8'hE0, 16'h001F, 0, 0);
    tick(100);
    cmd(0, 8'h50, 0, 1, 17'h10000);
    cmd(1, 8'h46, 16'h0011, 1, 17'h10000);
    cmd(0, 8'hE0, 0, 1, 17'h10000);
    cmd(0, 8'h47, 0, 0, 17'h10000);
    cmd(0, 8'h46, 0, 0, 17'h00064);
    probe(HOT, NI, 1'b0, NV, 8'h01);
    probe(NI, HOT, 1'b0, NV, 8'h80);
    probe(NI, HOT, 1'b1, NV, 8'h01);
    probe(16'h0020, NI, 1'b0, NV, 8'h02);
    probe(NI, 16'h0020, 1'b1, NV, 8'h02);
    probe(NI, NI, 1'b0, 16'h0060, 8'h10);
    ot(8'h80, 300, 0);
    ot(8'h91, 20, 2);
    ot(8'h97, 80, 2);
    ot(8'hB8, 10, 99);
    oth = 1'b1;
    tick(3);
    chk("other fault off", 17'(en), 17'h00000);
    oth = 1'b0;
    op_on = 1'b0;
    tick(3);
    chk("commanded off", 17'(en), 17'h00000);
    op_on = 1'b1;
    tick(3);
    chk("back on", 17'(en), 17'h00001);
    cmd(1, 8'h50, 16'h00C0, 0, 0);
    temp = HOT;
    tick(3);
    chk("resume off", 17'(en), 17'h00000);
    temp = WARM;
    tick(20);
    chk("above warning", 17'(en), 17'h00000);
    temp = COOL;
    tick(3);
    chk("resumed", 17'(en), 17'h00001);
    cmd(1, 8'hE0, 16'h001F, 0, 0);
    // reserved response codes only flag and alert
    for (int i = 0; i < 2; i++)
    begin
      cmd(1, 8'h50, i ? 16'h0040 : 16'h0000, 0, 0);
      temp = HOT;
      tick(5);
      chk("reserved enable", 17'(en), 17'h00001);
      cmd(0, 8'hE0, 0, 0, 17'h0000C);
      temp = COOL;
      cmd(1, 8'hE0, 16'h001F, 0, 0);
      tick(4);
    end
    chk("pending answers", 17'(expq.size()), 17'h00000);
    complete_run();
  end
endmodule
